/* File: bench/esfs_engine_model.sv */
// Behavioural engine behind the starter relay and fuel solenoid.
module esfs_engine_model #(
	parameter int SPIN_CYC = 30
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset_n,
	// Relay and solenoid drives.
	input wire logic crank,
	input wire logic fuel,
	// Engine state flags.
	output logic engine_running,
	output logic engine_stopped
);
	timeunit 1ns;
	timeprecision 1ns;
	int spin_q;
	// Speed builds only when cranked with fuel; without fuel it coasts down.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			spin_q <= 0;
		end else if (crank && fuel && spin_q < SPIN_CYC) begin
			spin_q <= spin_q + 1;
		end else if (!fuel && spin_q > 0) begin
			spin_q <= spin_q - 1;
		end
	end
	assign engine_running = fuel && spin_q == SPIN_CYC;
	assign engine_stopped = spin_q == 0;
endmodule // esfs_engine_model

/* File: bench/esfs_sequencer_tb.sv */
// Self-checking testbench for the engine start and fuel sequencer.
`include "esfs_map.svh"
module esfs_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] a; logic [31:0] v;} esfs_row_s;
	logic clk_sys = 0;
	logic reset_n = 0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic [31:0] rd_val;
	logic supply_hi = 1;
	logic off_reset_mode = 0;
	logic remap = 0;
	logic engine_running, engine_stopped, supply_24v, exc_current_hi;
	logic [5:0] out_batt;
	logic [3:0] out_aux;
	logic [7:0] thr_low, thr_high;
	int n_errors = 0;
	int n_tests = 0;
	int t;
	esfs_row_s rows[6] = '{'{`ESFS_ADDR_CTRL, 32'h0},
		'{`ESFS_ADDR_DLY, {`ESFS_STOP_DUR_RST, `ESFS_FUEL_DLY_RST}},
		'{`ESFS_ADDR_FSEL, {2'h0, `ESFS_FSEL_RST}},
		'{`ESFS_ADDR_USER, 32'h0}, '{`ESFS_ADDR_STAT, 32'h800},
		'{8'h20, 32'h0}};
	always #50 clk_sys = ~clk_sys;
	esfs_sequencer #(.MS_CYC(10)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.engine_running(engine_running), .engine_stopped(engine_stopped),
		.supply_hi(supply_hi), .off_reset_mode(off_reset_mode),
		.out_batt(out_batt), .out_aux(out_aux), .supply_24v(supply_24v),
		.thr_low(thr_low), .thr_high(thr_high),
		.exc_current_hi(exc_current_hi));
	// The crank relay follows output 0, or output 3 when remap is set.
	esfs_engine_model eng (.clk_sys(clk_sys), .reset_n(reset_n),
		.crank(remap ? out_batt[3] : out_batt[0]), .fuel(out_batt[1]),
		.engine_running(engine_running), .engine_stopped(engine_stopped));
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		rd_val = reg_rdata;
	endtask
	task automatic wait_out(int i, logic lvl);
		for (t = 0; t < 3000 && out_batt[i] !== lvl; t++) @(negedge clk_sys);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		report_and_stop();
	end
	initial begin
		@(negedge clk_sys);
		check("thr_low", thr_low, `ESFS_THR_LO_12);
		check("thr_high", thr_high, `ESFS_THR_HI_12);
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(negedge clk_sys);
		check("sup24", supply_24v, 1'b1);
		check("thr_low", thr_low, `ESFS_THR_LO_24);
		check("thr_high", thr_high, `ESFS_THR_HI_24);
		check("exc", exc_current_hi, 1'b1);
		foreach (rows[i]) begin
			rd(rows[i].a);
			check("reg", rd_val, rows[i].v);
		end
		$display("reset and register test done");
		@(posedge clk_sys);
		supply_hi <= 1'b0;
		off_reset_mode <= 1'b1;
		repeat (3) @(negedge clk_sys);
		check("sup24", supply_24v, 1'b0);
		check("exc", exc_current_hi, 1'b0);
		check("thr_low", thr_low, `ESFS_THR_LO_12);
		check("thr_high", thr_high, `ESFS_THR_HI_12);
		@(posedge clk_sys);
		off_reset_mode <= 1'b0;
		$display("supply class test done");
		wr(`ESFS_ADDR_CTRL, 32'h1);
		wait_out(1, 1'b1);
		check("crank", out_batt[0], 1'b0);
		wait_out(0, 1'b1);
		check("lead", t >= 2000, 1'b1);
		wait_out(0, 1'b0);
		check("release", t <= 33, 1'b1);
		rd(`ESFS_ADDR_STAT);
		check("state", rd_val[2:0], 3'h3);
		wr(`ESFS_ADDR_CTRL, 32'h2);
		wait_out(1, 1'b0);
		check("fuel_off", t <= 3, 1'b1);
		check("stop", out_batt[2], 1'b0);
		for (t = 0; t < 200 && !engine_stopped; t++) @(negedge clk_sys);
		rd(`ESFS_ADDR_STAT);
		check("state", rd_val[2:0], 3'h0);
		$display("plain start and stop test done");
		wr(`ESFS_ADDR_FSEL, 32'h0008_22d0);
		remap <= 1'b1;
		wr(`ESFS_ADDR_USER, 32'h1);
		wr(`ESFS_ADDR_DLY, 32'h0014_0005);
		@(negedge clk_sys);
		check("user", out_batt[0], 1'b1);
		wr(`ESFS_ADDR_CTRL, 32'h5);
		wait_out(4, 1'b1);
		check("aux", out_aux[0], 1'b1);
		wait_out(3, 1'b1);
		check("crank3", out_batt[3], 1'b1);
		wait_out(3, 1'b0);
		wr(`ESFS_ADDR_CTRL, 32'h6);
		wait_out(2, 1'b1);
		check("stop_on", out_batt[2], 1'b1);
		wait_out(4, 1'b0);
		check("delay", t >= 40 && t <= 62, 1'b1);
		wait_out(2, 1'b0);
		check("stop_off", t <= 35, 1'b1);
		$display("routing and delayed stop test done");
		report_and_stop();
	end
endmodule // esfs_sequencer_tb

/* File: rtl/esfs_map.svh */
// Register offsets, field positions, reset values and timing constants.
`ifndef ESFS_MAP_SVH
`define ESFS_MAP_SVH
`define ESFS_CLK_HZ 10000000
`define ESFS_MS_PER_S 1000
`define ESFS_FUEL_LEAD_MS 16'h00c8
`define ESFS_ADDR_CTRL 8'h00
`define ESFS_ADDR_DLY 8'h04
`define ESFS_ADDR_FSEL 8'h08
`define ESFS_ADDR_USER 8'h0c
`define ESFS_ADDR_STAT 8'h10
`define ESFS_CTRL_START 0
`define ESFS_CTRL_STOP 1
`define ESFS_CTRL_STOPEN 2
`define ESFS_N_OUT 10
`define ESFS_N_MAIN 6
`define ESFS_FS_W 3
`define ESFS_FN_USER 3'h0
`define ESFS_FN_CRANK 3'h1
`define ESFS_FN_FUEL 3'h2
`define ESFS_FN_STOP 3'h3
`define ESFS_FSEL_RST 30'h0000_00d1
`define ESFS_FUEL_DLY_RST 16'h0000
`define ESFS_STOP_DUR_RST 16'h2710
`define ESFS_THR_LO_12 8'h6e
`define ESFS_THR_HI_12 8'h96
`define ESFS_THR_LO_24 8'hdc
`define ESFS_THR_HI_24 8'hf0
`endif

/* File: rtl/esfs_pkg.sv */
// Types shared by the engine start and fuel sequencer.
package esfs_pkg;
	typedef enum logic [2:0] {
		ESFS_IDLE,
		ESFS_PRIME,
		ESFS_CRANK,
		ESFS_RUN,
		ESFS_STOPPING
	} esfs_state_e;

	typedef struct packed {
		esfs_state_e st;
		logic [13:0] pre;
		logic tick;
		logic [15:0] ms;
		logic [15:0] stp;
		logic stop_on;
		logic crank;
		logic fuel;
		logic stop_en;
		logic [15:0] fuel_dly;
		logic [15:0] stop_dur;
		logic [29:0] fsel;
		logic [9:0] user;
		logic [9:0] outs;
		logic init_done;
		logic mode_q;
		logic sup24;
		logic [7:0] thr_lo;
		logic [7:0] thr_hi;
		logic exc_hi;
		logic [31:0] rdata;
	} esfs_state_s;
endpackage

/* File: rtl/esfs_sequencer.sv */
// Engine start, fuel and stop output sequencer with supply class detection.
//
// How it works
// - Crank output goes on when the start sequence reaches cranking.
// - Crank output drops at most two cycles after engine running seen.
// - Fuel goes on first; crank follows no sooner than 200 ms later.
// - A stop command removes the fuel output.
// - With the stop output enabled, fuel drops after a programmed delay.
// - Output 0 carries crank by default and sources battery level.
// - Output 1 carries fuel by default.
// - Any output set to the crank code carries the crank function.
// - Any output set to the fuel code carries the fuel function.
// - The default crank output can be given another function.
// - Supply class is sampled at power-up and on off/reset entry.
// - Supply class picks voltage thresholds and excitation level.
// - Auxiliary outputs drive the common positive level when active.
// - Stop output ends when engine stops or the duration runs out.
`include "esfs_map.svh"

module esfs_sequencer
	import esfs_pkg::*;
#(
	parameter int MS_CYC = `ESFS_CLK_HZ / `ESFS_MS_PER_S
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset_n,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Engine and supply sensing.
	input wire logic engine_running,
	input wire logic engine_stopped,
	input wire logic supply_hi,
	input wire logic off_reset_mode,
	// Static outputs.
	output logic [5:0] out_batt,
	output logic [3:0] out_aux,
	// Supply class results.
	output logic supply_24v,
	output logic [7:0] thr_low,
	output logic [7:0] thr_high,
	output logic exc_current_hi
);

	esfs_state_s s_q;
	esfs_state_s s_d;
	logic [9:0] fn_val;
	logic wr_ctrl;
	logic start_p;
	logic stop_p;
	logic mode_rise;

	assign wr_ctrl = reg_wr && (reg_addr == `ESFS_ADDR_CTRL);
	assign start_p = wr_ctrl && reg_wdata[`ESFS_CTRL_START];
	assign stop_p = wr_ctrl && reg_wdata[`ESFS_CTRL_STOP];
	assign mode_rise = off_reset_mode && !s_q.mode_q;

	// Each output looks up its own function selector.
	for (genvar gi = 0; gi < `ESFS_N_OUT; gi++) begin : g_out
		logic [2:0] sel;
		assign sel = s_q.fsel[gi*`ESFS_FS_W +: `ESFS_FS_W];
		always_comb begin
			unique case (sel)
				`ESFS_FN_CRANK: fn_val[gi] = s_q.crank;
				`ESFS_FN_FUEL: fn_val[gi] = s_q.fuel;
				`ESFS_FN_STOP: fn_val[gi] = s_q.stop_on;
				default: fn_val[gi] = s_q.user[gi];
			endcase
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		s_d.rdata = 32'h0000_0000;
		s_d.outs = fn_val;
		if (s_q.pre == 14'(MS_CYC - 1)) begin
			s_d.pre = 14'h0000;
			s_d.tick = 1'b1;
		end else begin
			s_d.pre = s_q.pre + 14'h0001;
		end
		if (s_q.tick) begin
			s_d.ms = s_q.ms + 16'h0001;
			if (s_q.stop_on) begin
				s_d.stp = s_q.stp + 16'h0001;
			end
		end

		// Register writes; the control word's start and stop bits are pulses.
		if (reg_wr) begin
			unique case (reg_addr)
				`ESFS_ADDR_CTRL: s_d.stop_en = reg_wdata[`ESFS_CTRL_STOPEN];
				`ESFS_ADDR_DLY: begin
					s_d.fuel_dly = reg_wdata[15:0];
					s_d.stop_dur = reg_wdata[31:16];
				end
				`ESFS_ADDR_FSEL: s_d.fsel = reg_wdata[29:0];
				`ESFS_ADDR_USER: s_d.user = reg_wdata[9:0];
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				`ESFS_ADDR_CTRL: s_d.rdata = {29'h0, s_q.stop_en, 2'h0};
				`ESFS_ADDR_DLY: s_d.rdata = {s_q.stop_dur, s_q.fuel_dly};
				`ESFS_ADDR_FSEL: s_d.rdata = {2'h0, s_q.fsel};
				`ESFS_ADDR_USER: s_d.rdata = {22'h0, s_q.user};
				`ESFS_ADDR_STAT: s_d.rdata = {20'h0, s_q.sup24,
					engine_running, s_q.stop_on, s_q.fuel,
					s_q.crank, 4'h0, s_q.st};
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end

		unique case (s_q.st)
			ESFS_IDLE: begin
				if (start_p && !stop_p) begin
					s_d.st = ESFS_PRIME;
					s_d.fuel = 1'b1;
					s_d.ms = 16'h0000;
				end
			end
			ESFS_PRIME: begin
				// One extra tick covers the unknown prescaler phase.
				if (s_q.tick && s_q.ms == `ESFS_FUEL_LEAD_MS) begin
					s_d.st = ESFS_CRANK;
					s_d.crank = 1'b1;
				end
			end
			ESFS_CRANK: begin
				if (engine_running) begin
					s_d.crank = 1'b0;
					s_d.st = ESFS_RUN;
				end
			end
			ESFS_RUN: ;
			ESFS_STOPPING: begin
				if (s_q.tick && s_q.ms >= s_q.fuel_dly) begin
					s_d.fuel = 1'b0;
				end
				if (engine_stopped || s_q.stp >= s_q.stop_dur) begin
					s_d.stop_on = 1'b0;
				end
				if (!s_q.fuel && !s_q.stop_on) begin
					s_d.st = ESFS_IDLE;
				end
			end
			default: s_d.st = ESFS_IDLE;
		endcase

		// A stop ends any running sequence, cranking included.
		if (stop_p && s_q.st != ESFS_IDLE && s_q.st != ESFS_STOPPING) begin
			s_d.crank = 1'b0;
			s_d.ms = 16'h0000;
			if (s_q.stop_en) begin
				s_d.stop_on = 1'b1;
				s_d.stp = 16'h0000;
				s_d.st = ESFS_STOPPING;
			end else begin
				s_d.fuel = 1'b0;
				s_d.st = ESFS_IDLE;
			end
		end

		// The supply class is frozen between samples so thresholds stay put.
		s_d.mode_q = off_reset_mode;
		s_d.init_done = 1'b1;
		if (!s_q.init_done || mode_rise) begin
			s_d.sup24 = supply_hi;
			s_d.exc_hi = supply_hi;
			s_d.thr_lo = supply_hi ? `ESFS_THR_LO_24 : `ESFS_THR_LO_12;
			s_d.thr_hi = supply_hi ? `ESFS_THR_HI_24 : `ESFS_THR_HI_12;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '{st: ESFS_IDLE, pre: 14'h0, tick: 1'b0, ms: 16'h0,
				stp: 16'h0, stop_on: 1'b0, crank: 1'b0, fuel: 1'b0,
				stop_en: 1'b0, fuel_dly: `ESFS_FUEL_DLY_RST,
				stop_dur: `ESFS_STOP_DUR_RST, fsel: `ESFS_FSEL_RST,
				user: 10'h0, outs: 10'h0, init_done: 1'b0, mode_q: 1'b0,
				sup24: 1'b0, thr_lo: `ESFS_THR_LO_12,
				thr_hi: `ESFS_THR_HI_12, exc_hi: 1'b0,
				rdata: 32'h0};
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign out_batt = s_q.outs[5:0];
	assign out_aux = s_q.outs[9:6];
	assign supply_24v = s_q.sup24;
	assign thr_low = s_q.thr_lo;
	assign thr_high = s_q.thr_hi;
	assign exc_current_hi = s_q.exc_hi;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// Fuel must have been on for a whole prime phase before cranking.
	sequence fuel_prime;
		s_q.st == ESFS_PRIME && s_q.fuel;
	endsequence
	sequence crank_begins;
		$rose(s_q.crank);
	endsequence

	a_crank_on_entry: assert property (
		s_q.st == ESFS_PRIME && s_d.st == ESFS_CRANK |=> s_q.crank)
		else $error("crank not raised on entry to cranking");
	a_crank_release: assert property (
		s_q.crank && engine_running && !stop_p |=> !s_q.crank)
		else $error("crank held after engine running");
	a_fuel_before_crank: assert property (
		crank_begins |-> $past(s_q.fuel)
		&& $past(s_q.ms) >= `ESFS_FUEL_LEAD_MS)
		else $error("crank raised without fuel lead time");
	a_prime_holds: assert property (
		fuel_prime ##1 fuel_prime |-> !s_q.crank)
		else $error("crank on during fuel prime");
	a_fuel_stop: assert property (
		stop_p && !s_q.stop_en && s_q.st == ESFS_RUN |=> !s_q.fuel)
		else $error("fuel kept after stop");
	a_fuel_delay: assert property (
		$fell(s_q.fuel) && $past(s_q.st) == ESFS_STOPPING
		|-> $past(s_q.ms) >= $past(s_q.fuel_dly))
		else $error("fuel dropped before stop delay");
	a_out_map: assert property (
		s_q.fsel[2:0] == `ESFS_FN_CRANK |=> out_batt[0] == $past(s_q.crank))
		else $error("crank not routed to selected output");
	a_supply_sample: assert property (
		mode_rise |=> supply_24v == $past(supply_hi))
		else $error("supply class not sampled on off/reset");
	a_thresholds: assert property (
		supply_24v |-> thr_low == `ESFS_THR_LO_24 && exc_current_hi)
		else $error("thresholds do not follow supply class");
	a_stop_end: assert property (
		s_q.stop_on && engine_stopped && s_q.st == ESFS_STOPPING
		|=> !s_q.stop_on)
		else $error("stop output held after engine stopped");

	// Outputs follow their selector one cycle after the internal state.
	// Fixed output numbers are checked so that a misplaced slice shows up.
	a_fuel_route: assert property (
		s_q.fsel[1*`ESFS_FS_W +: `ESFS_FS_W] == `ESFS_FN_FUEL
		|=> out_batt[1] == $past(s_q.fuel))
		else $error("fuel not routed to second output");
	a_stop_route: assert property (
		s_q.fsel[2*`ESFS_FS_W +: `ESFS_FS_W] == `ESFS_FN_STOP
		|=> out_batt[2] == $past(s_q.stop_on))
		else $error("stop not routed to selected output");
	a_crank_reroute: assert property (
		s_q.fsel[3*`ESFS_FS_W +: `ESFS_FS_W] == `ESFS_FN_CRANK
		|=> out_batt[3] == $past(s_q.crank))
		else $error("crank not routed to fourth output");
	a_fuel_reroute: assert property (
		s_q.fsel[4*`ESFS_FS_W +: `ESFS_FS_W] == `ESFS_FN_FUEL
		|=> out_batt[4] == $past(s_q.fuel))
		else $error("fuel not routed to fifth output");
	a_aux_route: assert property (
		s_q.fsel[6*`ESFS_FS_W +: `ESFS_FS_W] == `ESFS_FN_FUEL
		|=> out_aux[0] == $past(s_q.fuel))
		else $error("fuel not routed to auxiliary output");
	a_user_route: assert property (
		s_q.fsel[0 +: `ESFS_FS_W] == `ESFS_FN_USER
		|=> out_batt[0] == $past(s_q.user[0]))
		else $error("user level not routed to first output");

	// Crank is only ever on with fuel and inside the cranking state.
	a_crank_fuel: assert property (
		s_q.crank |-> s_q.fuel && s_q.st == ESFS_CRANK)
		else $error("crank on without fuel or outside cranking");
	a_start_fuel: assert property (
		s_q.st == ESFS_IDLE && start_p && !stop_p
		|=> s_q.st == ESFS_PRIME && s_q.fuel && !s_q.crank)
		else $error("start did not begin with fuel alone");
	a_idle_quiet: assert property (
		s_q.st == ESFS_IDLE |-> !s_q.crank && !s_q.fuel && !s_q.stop_on)
		else $error("output left on in idle");
	a_stop_crank: assert property (
		stop_p && s_q.crank |=> !s_q.crank)
		else $error("crank kept after stop");

	// A stop with the stop output enabled moves to the stopping phase.
	sequence stop_enabled_req;
		stop_p && s_q.stop_en && s_q.st != ESFS_IDLE
		&& s_q.st != ESFS_STOPPING;
	endsequence
	sequence stop_held;
		s_q.st == ESFS_STOPPING && s_q.stop_on;
	endsequence
	a_stop_entry: assert property (
		stop_enabled_req |=> stop_held)
		else $error("stop output not raised on stop");
	a_fuel_on_tick: assert property (
		s_q.st == ESFS_STOPPING && !s_q.tick
		|=> s_q.fuel == $past(s_q.fuel))
		else $error("fuel changed between ms ticks while stopping");
	a_stop_limit: assert property (
		s_q.st == ESFS_STOPPING && s_q.stp >= s_q.stop_dur
		|=> !s_q.stop_on)
		else $error("stop output held past its duration");

	// The crank pin drops two edges after running is seen.
	sequence running_seen;
		s_q.crank && engine_running && !stop_p;
	endsequence
	sequence crank_on_first;
		s_q.fsel[0 +: `ESFS_FS_W] == `ESFS_FN_CRANK;
	endsequence
	a_release_pin: assert property (
		running_seen ##1 crank_on_first |=> !out_batt[0])
		else $error("crank pin held after engine running");

	// The class is sampled once after reset and then held until re-entry.
	a_power_sample: assert property (
		!s_q.init_done |=> supply_24v == $past(supply_hi))
		else $error("supply class not sampled after reset");
	a_class_hold: assert property (
		s_q.init_done && !mode_rise |=> $stable(supply_24v))
		else $error("supply class moved between samples");
	a_thr_12v: assert property (
		!supply_24v |-> thr_low == `ESFS_THR_LO_12
		&& thr_high == `ESFS_THR_HI_12 && !exc_current_hi)
		else $error("low class thresholds wrong");
	a_thr_high: assert property (
		supply_24v |-> thr_high == `ESFS_THR_HI_24)
		else $error("high threshold does not follow supply class");

	// Read data stand only in the cycle after a read strobe.
	a_read_idle: assert property (
		!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data not cleared after read cycle");

endmodule // esfs_sequencer
